// [rtl/core_sfr_bank.sv]
// Core CPU special function registers: work, stack, pointer, status regs
`timescale 1ns/10ps
module core_sfr_bank (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    output logic [7:0]       sfr_rdata,
    output logic             sfr_hit,
    input  wire logic        acc_load,
    input  wire logic [7:0]  acc_value,
    input  wire logic        dptr_inc,
    output logic [15:0]      active_dptr,
    output logic [15:0]      first_data_pointer,
    output logic [15:0]      second_data_pointer,
    output logic             pointer_reserved,
    output logic             trap_instruction_choose,
    output logic [1:0]       bank_number,
    output logic [4:0]       bank_base_addr,
    output logic [7:0]       acc_out,
    output logic [7:0]       psw_out,
    output logic [7:0]       sp_out
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0] sp_q, dp0l_q, dp0h_q, dp1l_q, dp1h_q;
    logic [7:0] eoc_q, psw_q, acc_q, b_q;
    logic       parity_q;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire sel_sp   = (sfr_addr == core_sfr_pkg::ADDR_SP);
    wire sel_dp0l = (sfr_addr == core_sfr_pkg::ADDR_DP0L);
    wire sel_dp0h = (sfr_addr == core_sfr_pkg::ADDR_DP0H);
    wire sel_dp1l = (sfr_addr == core_sfr_pkg::ADDR_DP1L);
    wire sel_dp1h = (sfr_addr == core_sfr_pkg::ADDR_DP1H);
    wire sel_eoc  = (sfr_addr == core_sfr_pkg::ADDR_EOC);
    wire sel_psw  = (sfr_addr == core_sfr_pkg::ADDR_PSW);
    wire sel_acc  = (sfr_addr == core_sfr_pkg::ADDR_ACC);
    wire sel_b    = (sfr_addr == core_sfr_pkg::ADDR_B);

    wire [2:0] psel = eoc_q[2:0];
    wire use_first  = (psel == core_sfr_pkg::PSEL_FIRST);
    wire use_second = (psel == core_sfr_pkg::PSEL_SECOND);

    wire [15:0] dp0 = {dp0h_q, dp0l_q};
    wire [15:0] dp1 = {dp1h_q, dp1l_q};
    // Reserved codes fall back to the first pointer so fetches stay sane
    wire [15:0] dsel = use_second ? dp1 : dp0;
    wire [15:0] dinc = dsel + 16'h0001;
    wire inc0 = dptr_inc && !use_second;
    wire inc1 = dptr_inc && use_second;

    // Helper registers parity of the next accumulator value, so the flag
    // changes in the same cycle as the register it describes
    wire [7:0] psw_view = {psw_q[7:1], parity_q};

    wire [7:0] rd_mux =
        sel_sp   ? sp_q   :
        sel_dp0l ? dp0l_q :
        sel_dp0h ? dp0h_q :
        sel_dp1l ? dp1l_q :
        sel_dp1h ? dp1h_q :
        sel_eoc  ? (eoc_q & core_sfr_pkg::EOC_WMASK) :
        sel_psw  ? psw_view :
        sel_acc  ? acc_q  :
        sel_b    ? b_q    : 8'h00;

    wire hit = sel_sp | sel_dp0l | sel_dp0h | sel_dp1l | sel_dp1h
             | sel_eoc | sel_psw | sel_acc | sel_b;

    // ----------------------------------------------------------------
    // Parity helper
    // ----------------------------------------------------------------
    wire [7:0] acc_d = (sfr_wr && sel_acc) ? sfr_wdata :
                       acc_load            ? acc_value : acc_q;

    parity_calc #(.WIDTH(8)) u_parity (
        .clk     (clk),
        .sys_rst (sys_rst),
        .data    (acc_d),
        .odd_q   (parity_q)
    );

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sp_q   <= core_sfr_pkg::RST_SP;
            acc_q  <= core_sfr_pkg::RST_ZERO;
            b_q    <= core_sfr_pkg::RST_ZERO;
            psw_q  <= core_sfr_pkg::RST_ZERO;
            eoc_q  <= core_sfr_pkg::RST_ZERO;
        end else begin
            acc_q <= acc_d;
            if (sfr_wr && sel_sp)  sp_q  <= sfr_wdata;
            if (sfr_wr && sel_b)   b_q   <= sfr_wdata;
            if (sfr_wr && sel_psw) psw_q <= sfr_wdata;
            if (sfr_wr && sel_eoc)
                eoc_q <= sfr_wdata & core_sfr_pkg::EOC_WMASK;
        end
    end

    // Bus write beats the auto increment on the same byte
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dp0l_q <= core_sfr_pkg::RST_ZERO;
            dp0h_q <= core_sfr_pkg::RST_ZERO;
            dp1l_q <= core_sfr_pkg::RST_ZERO;
            dp1h_q <= core_sfr_pkg::RST_ZERO;
        end else begin
            if (sfr_wr && sel_dp0l)  dp0l_q <= sfr_wdata;
            else if (inc0)           dp0l_q <= dinc[7:0];
            if (sfr_wr && sel_dp0h)  dp0h_q <= sfr_wdata;
            else if (inc0)           dp0h_q <= dinc[15:8];
            if (sfr_wr && sel_dp1l)  dp1l_q <= sfr_wdata;
            else if (inc1)           dp1l_q <= dinc[7:0];
            if (sfr_wr && sel_dp1h)  dp1h_q <= sfr_wdata;
            else if (inc1)           dp1h_q <= dinc[15:8];
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign sfr_rdata = rd_mux;
    assign sfr_hit = hit;
    assign active_dptr = dsel;
    assign first_data_pointer = dp0;
    assign second_data_pointer = dp1;
    assign pointer_reserved = !(use_first || use_second);
    // Software must hold this low; the core decodes it anyway
    assign trap_instruction_choose =
        eoc_q[core_sfr_pkg::EOC_TRAP_BIT];
    assign bank_number = {psw_q[core_sfr_pkg::PSW_BANK_HIGH_BIT],
                          psw_q[core_sfr_pkg::PSW_BANK_LOW_BIT]};
    assign bank_base_addr = {bank_number, 3'h0};
    assign acc_out = acc_q;
    assign psw_out = psw_view;
    assign sp_out = sp_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Parity is judged against the stored accumulator, the value software
    // reads back, so a misaligned helper shows up here
    a_parity_tracks_acc: assert property (
        @(posedge clk) disable iff (sys_rst)
        psw_out[core_sfr_pkg::PSW_PARITY_BIT] == ^acc_q)
        else $error("parity flag wrong");
    a_parity_after_load: assert property (
        @(posedge clk) disable iff (sys_rst)
        (acc_load && !(sfr_wr && sel_acc)) |=>
        psw_out[core_sfr_pkg::PSW_PARITY_BIT] == ^$past(acc_value))
        else $error("parity not taken from core load");
    a_acc_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sfr_wr && sel_acc) |=> acc_out == $past(sfr_wdata))
        else $error("accumulator write lost");
    a_pointer_select: assert property (
        @(posedge clk) disable iff (sys_rst)
        (eoc_q[2:0] == core_sfr_pkg::PSEL_SECOND) |->
        active_dptr == {dp1h_q, dp1l_q})
        else $error("second pointer not selected");
    a_pointer_first: assert property (
        @(posedge clk) disable iff (sys_rst)
        (eoc_q[2:0] == core_sfr_pkg::PSEL_FIRST) |->
        active_dptr == {dp0h_q, dp0l_q})
        else $error("first pointer not selected");
    // Reserved codes must not wander off to the second pointer
    a_pointer_reserved: assert property (
        @(posedge clk) disable iff (sys_rst)
        (eoc_q[2:0] > core_sfr_pkg::PSEL_SECOND) |->
        pointer_reserved && active_dptr == {dp0h_q, dp0l_q})
        else $error("reserved code handled wrong");
    a_second_inc: assert property (
        @(posedge clk) disable iff (sys_rst)
        (dptr_inc && !sfr_wr && eoc_q[2:0] == core_sfr_pkg::PSEL_SECOND)
        |=> second_data_pointer == $past(second_data_pointer) + 16'h0001
        && first_data_pointer == $past(first_data_pointer))
        else $error("second pointer step wrong");
    a_trap_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sfr_wr && sfr_addr == core_sfr_pkg::ADDR_EOC) |=>
        trap_instruction_choose ==
            $past(sfr_wdata[core_sfr_pkg::EOC_TRAP_BIT]))
        else $error("trap bit not stored");
    a_spare_bits_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        (eoc_q & ~core_sfr_pkg::EOC_WMASK) == 8'h00)
        else $error("spare control bits set");
    a_bank_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sfr_wr && sfr_addr == core_sfr_pkg::ADDR_PSW) |=>
        bank_number == $past({sfr_wdata[core_sfr_pkg::PSW_BANK_HIGH_BIT],
                              sfr_wdata[core_sfr_pkg::PSW_BANK_LOW_BIT]}))
        else $error("bank bits wrong");
    a_bank_base: assert property (
        @(posedge clk) disable iff (sys_rst)
        bank_base_addr == 5'(psw_out[core_sfr_pkg::PSW_BANK_HIGH_BIT -: 2]
            * core_sfr_pkg::BANK_REGS))
        else $error("bank base wrong");
    a_dptr_inc: assert property (
        @(posedge clk) disable iff (sys_rst)
        (dptr_inc && !sfr_wr && eoc_q[2:0] == core_sfr_pkg::PSEL_FIRST) |=>
        first_data_pointer == $past(first_data_pointer) + 16'h0001)
        else $error("pointer not incremented");
    // A bus write and a step on the same pointer: the written byte keeps
    // the bus value, the other byte still takes the step
    a_write_beats_inc: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sfr_wr && sel_dp0l && inc0) |=>
        dp0l_q == $past(sfr_wdata) && dp0h_q == $past(dinc[15:8]))
        else $error("write and step collide wrongly");
    a_sp_reset: assert property (
        @(posedge clk)
        $fell(sys_rst) |-> sp_out == core_sfr_pkg::RST_SP)
        else $error("stack pointer reset value wrong");
    a_unmapped_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        !sfr_hit |-> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    c_second_used: cover property (@(posedge clk) use_second && dptr_inc);
    c_trap_set: cover property (@(posedge clk) trap_instruction_choose);
    c_bank3: cover property (@(posedge clk) bank_number == 2'h3);
    c_reserved_code: cover property (@(posedge clk) pointer_reserved);
    c_write_step: cover property (@(posedge clk) sfr_wr && sel_dp0l && inc0);
endmodule : core_sfr_bank

// [rtl/core_sfr_pkg.sv]
// Constants for the core special function register bank
// Function
// - Status bit 0 holds accumulator parity, updated every cycle.
// - Pointer select 000 picks first pointer, 001 second; others reserved.
// - Trap choose bit 4: 0 post-increment code move, 1 software trap.
// - Status word bits 4 and 3 hold the two-bit register bank number.
// - Bank picks one of four eight-register groups in lowest 32 RAM bytes.
package core_sfr_pkg;
    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_SP    = 8'h81;
    localparam logic [7:0] ADDR_DP0L  = 8'h82;
    localparam logic [7:0] ADDR_DP0H  = 8'h83;
    localparam logic [7:0] ADDR_DP1L  = 8'h84;
    localparam logic [7:0] ADDR_DP1H  = 8'h85;
    localparam logic [7:0] ADDR_EOC   = 8'hA2;
    localparam logic [7:0] ADDR_PSW   = 8'hD0;
    localparam logic [7:0] ADDR_ACC   = 8'hE0;
    localparam logic [7:0] ADDR_B     = 8'hF0;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_SP     = 8'h07;
    localparam logic [7:0] RST_ZERO   = 8'h00;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PSW_PARITY_BIT     = 0;
    localparam int PSW_BANK_LOW_BIT   = 3;
    localparam int PSW_BANK_HIGH_BIT  = 4;
    localparam int EOC_TRAP_BIT       = 4;
    localparam logic [7:0] EOC_WMASK  = 8'h17;
    localparam logic [2:0] PSEL_FIRST  = 3'h0;
    localparam logic [2:0] PSEL_SECOND = 3'h1;
    localparam int BANK_REGS          = 8;
endpackage : core_sfr_pkg

// [rtl/parity_calc.sv]
// Even/odd parity of one WIDTH-bit word, registered
`timescale 1ns/10ps
module parity_calc #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] data,
    output logic                  odd_q
);
    if (WIDTH < 1) begin : g_width_check
        $error("parity_calc: WIDTH must be positive");
    end

    wire odd_d = ^data;

    always_ff @(posedge clk) begin
        if (sys_rst) odd_q <= 1'b0;
        else         odd_q <= odd_d;
    end
endmodule : parity_calc

// [tb/cpu_core_special_registers_tb.sv]
// Self-checking testbench for the core special function register bank
`timescale 1ns/10ps
module cpu_core_special_registers_tb;
    logic        clk;
    logic        sys_rst;
    logic [7:0]  sfr_addr;
    logic        sfr_wr;
    logic [7:0]  sfr_wdata;
    logic [7:0]  sfr_rdata;
    logic        sfr_hit;
    logic        acc_load;
    logic [7:0]  acc_value;
    logic        dptr_inc;
    logic [15:0] active_dptr;
    logic [15:0] first_data_pointer;
    logic [15:0] second_data_pointer;
    logic        pointer_reserved;
    logic        trap_instruction_choose;
    logic [1:0]  bank_number;
    logic [4:0]  bank_base_addr;
    logic [7:0]  acc_out;
    logic [7:0]  psw_out;
    logic [7:0]  sp_out;
    int          err_count;
    int          total_checks;
    logic [7:0]  map_addr [9] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85,
                                  8'hA2, 8'hD0, 8'hE0, 8'hF0};
    logic [7:0]  map_rst  [9] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00,
                                  8'h00, 8'h00, 8'h00, 8'h00};

    core_sfr_bank dut (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_hit(sfr_hit), .acc_load(acc_load), .acc_value(acc_value),
        .dptr_inc(dptr_inc), .active_dptr(active_dptr),
        .first_data_pointer(first_data_pointer),
        .second_data_pointer(second_data_pointer),
        .pointer_reserved(pointer_reserved),
        .trap_instruction_choose(trap_instruction_choose),
        .bank_number(bank_number), .bank_base_addr(bank_base_addr),
        .acc_out(acc_out), .psw_out(psw_out), .sp_out(sp_out));

    always #20 clk = ~clk;

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge clk);
        sfr_wr    <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge clk);
        sfr_addr <= a;
        #1;
        chk("read data", {8'h00, exp}, {8'h00, sfr_rdata});
    endtask : rd

    task automatic pulse(logic inc, logic ld, logic [7:0] v);
        @(posedge clk);
        dptr_inc  <= inc;
        acc_load  <= ld;
        acc_value <= v;
        @(posedge clk);
        dptr_inc  <= 1'b0;
        acc_load  <= 1'b0;
        #1;
    endtask : pulse

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        acc_load = 1'b0;
        acc_value = 8'h00;
        dptr_inc = 1'b0;
        err_count = 0;
        total_checks = 0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 9; i++) rd(map_addr[i], map_rst[i]);
        rd(8'h86, 8'h00);
        chk("unmapped hit", 16'h0000, {15'h0, sfr_hit});
        wr(8'hE0, 8'h03);
        chk("parity even", 16'h0000, {15'h0, psw_out[0]});
        wr(8'hE0, 8'h07);
        wr(8'hD0, 8'h18);
        chk("bank number", 16'h0003, {14'h0, bank_number});
        chk("bank base", 16'h0018, {11'h0, bank_base_addr});
        rd(8'hD0, 8'h19);
        chk("mapped hit", 16'h0001, {15'h0, sfr_hit});
        pulse(1'b0, 1'b1, 8'h01);
        chk("load parity", 16'h0001, {15'h0, psw_out[0]});
        chk("acc load", 16'h0001, {8'h00, acc_out});
        wr(8'hE0, 8'h03);
        wr(8'hD0, 8'hE7);
        rd(8'hD0, 8'hE6);
        chk("status out", 16'h00E6, {8'h00, psw_out});
        for (int i = 0; i < 9; i++)
            if (i != 6) wr(map_addr[i], 8'hA5 ^ i[7:0]);
        for (int i = 0; i < 5; i++) rd(map_addr[i], 8'hA5 ^ i[7:0]);
        rd(8'hA2, 8'h17 & (8'hA5 ^ 8'h05));
        rd(8'hE0, 8'hA5 ^ 8'h07);
        rd(8'hF0, 8'hA5 ^ 8'h08);
        chk("stack out", 16'h00A5, {8'h00, sp_out});
        chk("acc out", 16'h00A2, {8'h00, acc_out});
        wr(8'hA2, 8'hFF);
        rd(8'hA2, 8'h17);
        chk("trap choose", 16'h0001, {15'h0, trap_instruction_choose});
        chk("reserved code", 16'h0001, {15'h0, pointer_reserved});
        wr(8'hA2, 8'h00);
        chk("trap cleared", 16'h0000, {15'h0, trap_instruction_choose});
        wr(8'h83, 8'h12);
        wr(8'h82, 8'hFF);
        wr(8'h85, 8'hAB);
        wr(8'h84, 8'hCD);
        chk("first pointer", 16'h12FF, first_data_pointer);
        chk("second pointer", 16'hABCD, second_data_pointer);
        pulse(1'b1, 1'b0, 8'h00);
        chk("active first", 16'h1300, active_dptr);
        @(posedge clk);
        sfr_addr  <= 8'h82;
        sfr_wdata <= 8'h40;
        sfr_wr    <= 1'b1;
        dptr_inc  <= 1'b1;
        @(posedge clk);
        sfr_wr    <= 1'b0;
        dptr_inc  <= 1'b0;
        #1;
        chk("write beats step", 16'h1340, first_data_pointer);
        wr(8'hA2, 8'h01);
        chk("active second", 16'hABCD, active_dptr);
        pulse(1'b1, 1'b0, 8'h00);
        chk("second inc", 16'hABCE, second_data_pointer);
        chk("first held", 16'h1340, first_data_pointer);
        wr(8'hA2, 8'h02);
        chk("reserved flag", 16'h0001, {15'h0, pointer_reserved});
        chk("reserved use", 16'h1340, active_dptr);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 9; i++) rd(map_addr[i], map_rst[i]);
        chk("reset parity", 16'h0000, {15'h0, psw_out[0]});
        chk("reset select", 16'h0000, {15'h0, pointer_reserved});
        finish_test();
    end

    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        finish_test();
    end
endmodule : cpu_core_special_registers_tb
